// ===== rtl/lbt_test_control.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps

// Notes on behaviour
// - Data indicators red on idle one, green on zero.
// - Clear-to-send indicator green while clear-to-send output asserted.
// - Carrier indicator red without remote carrier, green with it.
// - Terminal-ready indicator green while terminal asserts ready.
// - Bit error indicator red when receive path flags likely error.
// - During pattern test, error indicator flashes on each mismatch detected while locked.
// - Test mode indicator red in any test, local or remote requested.
// - No-sync indicator red until connection with remote established.
// - Local loop from panel toggle or terminal request line.
// - Local loop feeds own transmitter to own receiver; test mode shown.
// - Local loop returns terminal data on receive data output; with pattern test on, the code returns line receive data there instead.
// - Remote loop requested from panel toggle or terminal request line.
// - Remote unit in remote loop sends back all received line data while its own pattern test is off.
// - Remote loop request from line honoured only when response enabled.
// - Panel switches and terminal lines start tests with equal effect.
// - Pattern switch up: send 511 pattern, check returned stream.
// - Pattern switch down: inject deliberate errors into the pattern.
// - Pattern error count kept, cleared by operator clear command.
// - Remote loop combines with pattern test, with or without errors.
module lbt_test_control
  import lbt_pkg::*;
#(
  parameter int FLASH_LEN = lbt_pkg::FLASH_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bit_tick,
  input wire logic term_tx_data,
  input wire logic term_dtr,
  input wire logic term_rts,
  input wire logic term_local_req,
  input wire logic term_remote_req,
  input wire logic panel_local,
  input wire logic panel_remote,
  input wire logic panel_pattern,
  input wire logic panel_inject,
  input wire logic line_rx_data,
  input wire logic line_carrier,
  input wire logic line_synced,
  input wire logic line_bit_error,
  input wire logic line_remote_req,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic line_tx_data,
  output logic line_remote_req_out,
  output logic term_rx_data,
  output logic term_cts,
  output logic tx_data_green,
  output logic rx_data_green,
  output logic cts_green,
  output logic carrier_green,
  output logic dtr_green,
  output logic bit_error_indicator,
  output logic test_mode_indicator,
  output logic no_sync_indicator
);
  import lbt_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NIN = 14;
  logic [NIN-1:0] in_raw, sync_a, sync_b, next_sync_a, next_sync_b;

  assign in_raw = {term_tx_data, term_dtr, term_rts, term_local_req, term_remote_req,
                   panel_local, panel_remote, panel_pattern, panel_inject,
                   line_rx_data, line_carrier, line_synced, line_bit_error,
                   line_remote_req};

  always_comb
  begin
    next_sync_a = in_raw;
    next_sync_b = sync_a;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  logic s_txd, s_dtr, s_rts, s_lreq, s_rreq, s_plocal, s_premote, s_ppat, s_pinj;
  logic s_rxd, s_car, s_sync, s_berr, s_line_rreq;
  assign {s_txd, s_dtr, s_rts, s_lreq, s_rreq, s_plocal, s_premote, s_ppat, s_pinj,
          s_rxd, s_car, s_sync, s_berr, s_line_rreq} = sync_b;

  // ****************************************
  // Control register
  // ****************************************
  logic [7:0] ctrl, next_ctrl;
  logic [15:0] err_count, next_err_count;
  logic [15:0] next_rdata;
  logic [7:0] status;

  always_comb
  begin
    next_ctrl = ctrl;
    next_rdata = '0;
    if (reg_write && reg_addr == ADDR_CTRL)
      next_ctrl = reg_wdata;
    else
      next_ctrl[CTRL_CLEAR] = 1'b0;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_CTRL: next_rdata = {8'h00, ctrl};
        ADDR_STATUS: next_rdata = {8'h00, status};
        ADDR_ERR_COUNT: next_rdata = err_count;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= CTRL_RESET;
      reg_rdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  logic want_local, want_remote, remote_granted, pattern_on, inject_on;
  lbt_mode_t mode, next_mode;

  // Panel, pin or register source has the same effect; local wins if both asked
  assign want_local = s_plocal | s_lreq | ctrl[CTRL_LOCAL_LOOP];
  assign want_remote = s_premote | s_rreq | ctrl[CTRL_REMOTE_LOOP];
  assign remote_granted = s_line_rreq & ctrl[CTRL_RESPONSE_EN];
  assign pattern_on = s_ppat | s_pinj | ctrl[CTRL_PATTERN] | ctrl[CTRL_INJECT];
  assign inject_on = s_pinj | ctrl[CTRL_INJECT];

  always_comb
  begin
    if (want_local)
      next_mode = LBT_LOCAL;
    else if (want_remote)
      next_mode = LBT_REMOTE;
    else
      next_mode = LBT_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode <= LBT_IDLE;
    else
      mode <= next_mode;
  end

  // ****************************************
  // Pattern generator and detector
  // ****************************************
  function automatic logic prbs_fb(input logic [8:0] s);
    prbs_fb = s[PRBS_LEN-1] ^ s[PRBS_TAP-1];
  endfunction

  logic [8:0] gen, next_gen, det, next_det;
  logic [6:0] inj_cnt, next_inj_cnt;
  logic [4:0] good_cnt, next_good_cnt;
  logic [3:0] bad_cnt, next_bad_cnt;
  logic locked, next_locked;
  logic tx_bit, rx_bit, mismatch;
  logic [23:0] flash_cnt, next_flash_cnt;

  // Deliberate error on one bit in every interval
  assign tx_bit = prbs_fb(gen) ^ (inject_on && inj_cnt == 7'(INJECT_INTERVAL - 1));
  // Local loop: transmitter feeds own receiver
  assign rx_bit = (mode == LBT_LOCAL) ? line_tx_data : s_rxd;
  assign mismatch = bit_tick && pattern_on && (rx_bit != prbs_fb(det));

  always_comb
  begin
    next_gen = gen;
    next_det = det;
    next_inj_cnt = inj_cnt;
    next_good_cnt = good_cnt;
    next_bad_cnt = bad_cnt;
    next_locked = locked;
    next_err_count = err_count;
    next_flash_cnt = (flash_cnt != '0) ? flash_cnt - 24'h000001 : flash_cnt;
    if (!pattern_on)
    begin
      next_locked = 1'b0;
      next_good_cnt = '0;
      next_bad_cnt = '0;
      next_inj_cnt = '0;
    end
    else if (bit_tick)
    begin
      next_gen = {gen[7:0], prbs_fb(gen)};
      next_inj_cnt = (inj_cnt == 7'(INJECT_INTERVAL - 1)) ? '0 : inj_cnt + 7'h01;
      // Self-synchronising: load received bits, check against prediction
      next_det = {det[7:0], rx_bit};
      if (!locked)
      begin
        next_good_cnt = mismatch ? '0 : good_cnt + 5'h01;
        if (good_cnt == 5'(SYNC_GOOD_BITS - 1) && !mismatch)
        begin
          next_locked = 1'b1;
          next_bad_cnt = '0;
        end
      end
      else if (mismatch)
      begin
        // Count errors only once locked
        if (err_count != 16'hffff)
          next_err_count = err_count + 16'h0001;
        next_flash_cnt = 24'(FLASH_LEN);
        next_bad_cnt = bad_cnt + 4'h1;
        if (bad_cnt == 4'(SYNC_BAD_BITS - 1))
        begin
          next_locked = 1'b0;
          next_good_cnt = '0;
        end
      end
    end
    // Clear wins over a simultaneous increment
    if (ctrl[CTRL_CLEAR])
      next_err_count = ERR_COUNT_RESET;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen <= PRBS_SEED;
      det <= '0;
      inj_cnt <= '0;
      good_cnt <= '0;
      bad_cnt <= '0;
      locked <= 1'b0;
      err_count <= ERR_COUNT_RESET;
      flash_cnt <= '0;
    end
    else
    begin
      gen <= next_gen;
      det <= next_det;
      inj_cnt <= next_inj_cnt;
      good_cnt <= next_good_cnt;
      bad_cnt <= next_bad_cnt;
      locked <= next_locked;
      err_count <= next_err_count;
      flash_cnt <= next_flash_cnt;
    end
  end

  // ****************************************
  // Data paths and indicators
  // ****************************************
  logic n_line_tx, n_term_rx, n_cts, n_rreq_out, n_tm;
  logic [7:0] next_leds;

  assign status = {2'b00, locked, remote_granted, inject_on, pattern_on,
                   mode == LBT_REMOTE, mode == LBT_LOCAL};

  always_comb
  begin
    n_line_tx = pattern_on ? tx_bit : s_txd;
    if (remote_granted && !pattern_on)
      n_line_tx = s_rxd;
    n_term_rx = (mode == LBT_LOCAL && !pattern_on) ? s_txd : s_rxd;
    n_cts = s_rts & s_car;
    n_rreq_out = (mode == LBT_REMOTE);
    n_tm = (mode != LBT_IDLE) || pattern_on || remote_granted;
    next_leds[0] = !term_rx_data;
    next_leds[1] = !s_txd;
    next_leds[2] = term_cts;
    next_leds[3] = s_car;
    next_leds[4] = s_dtr;
    next_leds[5] = pattern_on ? (flash_cnt != '0) : s_berr;
    next_leds[6] = n_tm;
    next_leds[7] = !s_sync;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_tx_data <= 1'b1;
      term_rx_data <= 1'b1;
      term_cts <= 1'b0;
      line_remote_req_out <= 1'b0;
      test_mode_indicator <= 1'b0;
      {no_sync_indicator, bit_error_indicator, dtr_green, carrier_green,
       cts_green, tx_data_green, rx_data_green} <= 7'h40;
    end
    else
    begin
      line_tx_data <= n_line_tx;
      term_rx_data <= n_term_rx;
      term_cts <= n_cts;
      line_remote_req_out <= n_rreq_out;
      test_mode_indicator <= next_leds[6];
      rx_data_green <= next_leds[0];
      tx_data_green <= next_leds[1];
      cts_green <= next_leds[2];
      carrier_green <= next_leds[3];
      dtr_green <= next_leds[4];
      bit_error_indicator <= next_leds[5];
      no_sync_indicator <= next_leds[7];
    end
  end

endmodule

// ===== shared/lbt_pkg.sv
package lbt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_ERR_COUNT = 4'h2;

  // Control register fields
  localparam int CTRL_LOCAL_LOOP = 0;
  localparam int CTRL_REMOTE_LOOP = 1;
  localparam int CTRL_PATTERN = 2;
  localparam int CTRL_INJECT = 3;
  localparam int CTRL_RESPONSE_EN = 4;
  localparam int CTRL_CLEAR = 5;
  localparam logic [7:0] CTRL_RESET = 8'h10;

  // ****************************************
  // Pattern engine
  // ****************************************
  localparam int PRBS_LEN = 9;
  localparam int PRBS_TAP = 5;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam int SYNC_GOOD_BITS = 16;
  localparam int SYNC_BAD_BITS = 8;
  localparam int INJECT_INTERVAL = 64;
  localparam logic [15:0] ERR_COUNT_RESET = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int FLASH_MS = 50;
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;

  typedef enum logic [2:0]
  {
    LBT_IDLE = 3'b001,
    LBT_LOCAL = 3'b010,
    LBT_REMOTE = 3'b100
  } lbt_mode_t;

endpackage

// ===== testbench/lbt_chk.sv
`timescale 1ns/100ps
module lbt_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic term_tx_data,
  input wire logic term_local_req,
  input wire logic term_remote_req,
  input wire logic panel_local,
  input wire logic panel_remote,
  input wire logic panel_pattern,
  input wire logic line_carrier,
  input wire logic line_synced,
  input wire logic line_bit_error,
  input wire logic term_rx_data,
  input wire logic term_cts,
  input wire logic line_remote_req_out,
  input wire logic tx_data_green,
  input wire logic cts_green,
  input wire logic carrier_green,
  input wire logic bit_error_indicator,
  input wire logic test_mode_indicator,
  input wire logic no_sync_indicator
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ***
  // Pins pass two sync stages, so give each relation room
  // ***
  property p_txd; $stable(term_tx_data)[*5] |-> tx_data_green == !term_tx_data; endproperty
  a_txd: assert property (p_txd) else $error("tx led");
  property p_cts; term_cts[*4] |-> cts_green; endproperty
  a_cts: assert property (p_cts) else $error("cts led");
  property p_cd; $fell(line_carrier) |-> ##[1:4] !carrier_green; endproperty
  a_cd: assert property (p_cd) else $error("carrier led");
  property p_err; line_bit_error[*5] |-> bit_error_indicator; endproperty
  a_err: assert property (p_err) else $error("error led");
  property p_tm;
    (panel_local || panel_remote || term_local_req || term_remote_req)[*6] |-> test_mode_indicator;
  endproperty
  a_tm: assert property (p_tm) else $error("test led");
  property p_ns; $stable(line_synced)[*5] |-> no_sync_indicator == !line_synced; endproperty
  a_ns: assert property (p_ns) else $error("sync led");
  property p_llb;
    (term_local_req && !panel_pattern && $stable(term_tx_data))[*7] |-> term_rx_data == term_tx_data;
  endproperty
  a_llb: assert property (p_llb) else $error("local echo");
  property p_rdl;
    $rose(term_remote_req) && !term_local_req && !panel_local |-> ##[1:5] line_remote_req_out;
  endproperty
  a_rdl: assert property (p_rdl) else $error("remote request");
  c_rdl: cover property (line_remote_req_out && test_mode_indicator);
  c_err: cover property (panel_pattern ##1 $rose(bit_error_indicator));
  c_llb: cover property (term_local_req && test_mode_indicator);
endmodule

// ===== testbench/lbt_peer.sv
`timescale 1ns/100ps
// ***
// Far unit, always willing to loop
// ***
module lbt_peer (
  input wire logic clk,
  input wire logic tx,
  input wire logic loop_req,
  input wire logic own_data,
  output logic rx
);
  initial rx = 1'b1;
  always @(posedge clk)
  begin
    rx <= loop_req ? tx : own_data;
  end
endmodule

// ===== testbench/loopback_ber_test_control_tb.sv
`timescale 1ns/100ps
module loopback_ber_test_control_tb;
  import lbt_pkg::*;
  logic clk, arst_n, bit_tick, term_tx_data, term_dtr, term_rts, term_local_req;
  logic term_remote_req, panel_local, panel_remote, panel_pattern, panel_inject;
  logic line_rx_data, line_carrier, line_synced, line_bit_error, line_remote_req;
  logic reg_write, reg_read, line_tx_data, line_remote_req_out, term_rx_data, term_cts;
  logic tx_data_green, rx_data_green, cts_green, carrier_green, dtr_green;
  logic bit_error_indicator, test_mode_indicator, no_sync_indicator, own, prev, b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [15:0] reg_rdata, d, e;
  logic [1:0] tc;
  int fails, compares, cnt, fl;
  bit q[$];

  lbt_test_control #(.FLASH_LEN(4)) dut_u (.*);
  lbt_peer peer_u (.clk(clk), .tx(line_tx_data), .loop_req(line_remote_req_out),
    .own_data(own), .rx(line_rx_data));

  // ***
  // Tasks
  // ***
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] want);
    compares++;
    if (got !== want)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // Mid-cycle sampling keeps checks clear of the launching edge
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wreg(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rreg(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Sources 0-2 local, 3-5 remote: panel, pin, register
  task automatic src(int s, logic v);
    @(posedge clk);
    panel_local <= v && s == 0;
    term_local_req <= v && s == 1;
    panel_remote <= v && s == 3;
    term_remote_req <= v && s == 4;
    wreg(ADDR_CTRL, v && s == 2 ? 8'h11 : v && s == 5 ? 8'h12 : CTRL_RESET);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    tc <= tc + 2'd1;
    bit_tick <= tc == 2'd3;
    cnt <= cnt + 1;
    if (cnt == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ***
  // Stimulus
  // ***
  initial
  begin
    {arst_n, bit_tick, term_dtr, term_rts, term_local_req, term_remote_req} = '0;
    {panel_local, panel_remote, panel_pattern, panel_inject, line_carrier} = '0;
    {line_synced, line_bit_error, line_remote_req, reg_write, reg_read, own, prev} = '0;
    {reg_addr, reg_wdata, tc, term_tx_data} = 15'h1;
    void'($urandom(32'hde6e));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    chk(16'(no_sync_indicator), 16'h1);
    wreg(4'hf, 8'hff);
    rreg(4'hf);
    chk(d, 16'h0);
    rreg(ADDR_ERR_COUNT);
    chk(d, ERR_COUNT_RESET);
    rreg(ADDR_CTRL);
    chk(d, 16'(CTRL_RESET));
    $display("reset test done");
    repeat (8)
    begin
      e = 16'($urandom);
      @(posedge clk);
      {own, term_tx_data, term_dtr, term_rts} <= e[6:3];
      {line_carrier, line_synced, line_bit_error} <= e[2:0];
      cyc(7);
      d = {10'h0, rx_data_green, tx_data_green, dtr_green, carrier_green, no_sync_indicator,
           bit_error_indicator};
      chk(d, {10'h0, ~e[6], ~e[5], e[4], e[2], ~e[1], e[0]});
      chk(16'(cts_green), 16'(term_cts));
    end
    @(posedge clk);
    {own, term_tx_data, term_rts, line_carrier, line_synced, line_bit_error} <= 6'b011110;
    $display("indicator test done");
    for (int s = 0; s < 6; s++)
    begin
      src(s, 1'b1);
      cyc(8);
      chk({14'h0, test_mode_indicator, line_remote_req_out}, {15'h1, s > 2});
      repeat (4)
      begin
        b = 1'($urandom);
        q.push_back(b);
        @(posedge clk);
        term_tx_data <= b;
        cyc(14);
        chk(16'(term_rx_data), 16'(q.pop_front()));
      end
      src(s, 1'b0);
      cyc(8);
      chk(16'(test_mode_indicator), 16'h0);
    end
    $display("loopback test done");
    @(posedge clk);
    line_remote_req <= 1'b1;
    term_tx_data <= 1'b1;
    for (int en = 1; en >= 0; en--)
    begin
      wreg(ADDR_CTRL, en[0] ? 8'h10 : 8'h00);
      cyc(10);
      chk({14'h0, test_mode_indicator, line_tx_data}, {14'h0, en[0], !en[0]});
    end
    @(posedge clk);
    line_remote_req <= 1'b0;
    src(0, 1'b0);
    $display("far request test done");
    for (int m = 0; m < 2; m++)
    begin
      src(m * 3, 1'b1);
      // Second pass drives the pattern from the register instead of the panel
      if (m == 0)
      begin
        @(posedge clk);
        panel_pattern <= 1'b1;
      end
      else
        wreg(ADDR_CTRL, 8'h14);
      cyc(800);
      rreg(ADDR_STATUS);
      chk(16'(d[5]), 16'h1);
      rreg(ADDR_ERR_COUNT);
      chk(d, 16'h0);
      if (m == 0)
      begin
        @(posedge clk);
        panel_inject <= 1'b1;
      end
      else
        wreg(ADDR_CTRL, 8'h18);
      fl = 0;
      repeat (1500)
      begin
        @(negedge clk);
        fl += int'(bit_error_indicator && !prev);
        prev = bit_error_indicator;
      end
      chk(16'(fl > 0), 16'h1);
      @(posedge clk);
      {panel_pattern, panel_inject} <= 2'b00;
      rreg(ADDR_ERR_COUNT);
      chk(16'(d != 0), 16'h1);
      wreg(ADDR_CTRL, 8'h30);
      rreg(ADDR_ERR_COUNT);
      chk(d, 16'h0);
      src(m * 3, 1'b0);
    end
    $display("pattern test done");
    end_of_test();
  end
endmodule

bind lbt_test_control lbt_chk chk_u (.*);
